// [hw/srst_map.vh]
// Constants for the slow-clock reset controller
`ifndef SRST_MAP_VH
`define SRST_MAP_VH
`define SRST_TYPE_GENERAL 3'h0
`define SRST_TYPE_WAKEUP 3'h1
`define SRST_TYPE_USER 3'h4
`define SRST_PROC_STARTUP 2'h3
`define SRST_BOOT_DELAY 2'h3
`define SRST_STARTUP_CYCLES 16'h0400
`define SRST_PULSE_LENGTH_FIELD_RESET 4'h0
`define SRST_ST_BACKUP 3'h0
`define SRST_ST_STARTUP 3'h1
`define SRST_ST_CLKRUN 3'h2
`define SRST_ST_RUN 3'h3
`define SRST_ST_CORE_OFF 3'h4
`define SRST_ST_USER 3'h5
`endif

// [hw/srst_controller.v]
// Slow-clock reset sequencer with pin shaping and boot-select capture
`timescale 1ns/100ps
`default_nettype none
`include "srst_map.vh"

module srst_controller #(
   parameter STARTUP_CYCLES = 1024
) (
   input wire CLOCK,
   input wire RESET_N,
   input wire BACKUP_POR_N,
   input wire CORE_POR_N,
   input wire PIN_IN,
   output reg PIN_OUT,
   output wire PIN_OE_N,
   input wire BOOT_SELECT_PIN,
   output reg BOOT_SELECT,
   input wire MODE_WRITE,
   input wire USER_RESET_ENABLE_IN,
   input wire USER_RESET_IRQ_ENABLE_IN,
   input wire [3:0] PULSE_LENGTH_IN,
   output reg USER_RESET_ENABLE,
   output reg USER_RESET_IRQ_ENABLE,
   output reg [3:0] PULSE_LENGTH_FIELD,
   input wire STATUS_READ,
   output reg PIN_LEVEL_STATUS,
   output reg USER_RESET_SEEN,
   output reg [2:0] LAST_RESET_TYPE,
   output wire USER_RESET_IRQ,
   output wire PROC_CLK_EN,
   output wire PROC_RESET_N,
   output wire WDT_RESET_N,
   output wire BACKUP_RESET_N,
   output wire PERIPH_RESET_N
);
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [15:0] cnt_ff;
   reg [15:0] nxt_cnt;
   reg pin_s1_ff;
   reg pin_s2_ff;
   reg pin_prev_ff;
   reg core_s1_ff;
   reg core_s2_ff;
   reg core_prev_ff;
   reg bkp_s1_ff;
   reg bkp_s2_ff;
   reg boot_s1_ff;
   reg boot_s2_ff;
   reg [1:0] boot_cnt_ff;
   reg boot_arm_ff;
   reg proc_rst_n_ff;
   reg per_rst_n_ff;
   reg bkp_rst_n_ff;
   reg ext_req_ff;
   reg [16:0] pulse_cnt_ff;
   reg [2:0] pend_type_ff;
   reg [2:0] nxt_type;
   reg nxt_proc;
   reg nxt_per;
   reg nxt_bkp;
   reg nxt_ext;
   wire pin_low;
   wire core_up;
   wire user_trig;
   wire [16:0] pulse_len;
   wire bkp_ok;
   wire [15:0] startup_len;

   assign pin_low = ~pin_s2_ff;
   assign core_up = core_s2_ff;
   // Sequencing sees the backup detector only after two flops
   assign bkp_ok = bkp_s2_ff;
   assign startup_len = STARTUP_CYCLES[15:0];
   // pulse length math
   // Seventeen bits: the longest pulse, 2^16 cycles, overflows sixteen
   assign pulse_len = 17'h00001 << ({1'b0, PULSE_LENGTH_FIELD} + 5'h01);
   // user request, gated by enable, suppressed by irq mode
   assign user_trig = pin_low & USER_RESET_ENABLE & ~USER_RESET_IRQ_ENABLE;
   assign USER_RESET_IRQ = USER_RESET_SEEN & USER_RESET_IRQ_ENABLE & ~USER_RESET_ENABLE;

   // Raw detector levels gate the outputs so a supply loss needs no clock edge
   // backup low forces all; core fall asserts at once
   assign BACKUP_RESET_N = bkp_rst_n_ff & BACKUP_POR_N;
   assign PROC_RESET_N = proc_rst_n_ff & BACKUP_POR_N & CORE_POR_N;
   assign WDT_RESET_N = PROC_RESET_N;
   assign PERIPH_RESET_N = per_rst_n_ff & BACKUP_POR_N & CORE_POR_N;
   assign PROC_CLK_EN = (state_ff == `SRST_ST_CLKRUN) | (state_ff == `SRST_ST_RUN) | (state_ff == `SRST_ST_USER);
   // Pin is open drain: enable low while pulling the line down
   assign PIN_OE_N = PIN_OUT;

   // two-flop resync of pin and core detector
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_ff <= 1'b1;
         pin_s2_ff <= 1'b1;
         pin_prev_ff <= 1'b1;
         core_s1_ff <= 1'b0;
         core_s2_ff <= 1'b0;
         core_prev_ff <= 1'b0;
      end else begin
         pin_s1_ff <= PIN_IN;
         pin_s2_ff <= pin_s1_ff;
         pin_prev_ff <= pin_s2_ff;
         core_s1_ff <= CORE_POR_N;
         core_s2_ff <= core_s1_ff;
         core_prev_ff <= core_s2_ff;
      end
   end

   // Detector and boot pin come from outside the clock; only the second flop feeds logic
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         bkp_s1_ff <= 1'b0;
         bkp_s2_ff <= 1'b0;
         boot_s1_ff <= 1'b0;
         boot_s2_ff <= 1'b0;
      end else begin
         bkp_s1_ff <= BACKUP_POR_N;
         bkp_s2_ff <= bkp_s1_ff;
         boot_s1_ff <= BOOT_SELECT_PIN;
         boot_s2_ff <= boot_s1_ff;
      end
   end

   // mode bits reset only by backup supply loss
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         USER_RESET_ENABLE <= 1'b0;
         USER_RESET_IRQ_ENABLE <= 1'b0;
         PULSE_LENGTH_FIELD <= `SRST_PULSE_LENGTH_FIELD_RESET;
      end else if (!(bkp_rst_n_ff & bkp_ok)) begin
         USER_RESET_ENABLE <= 1'b0;
         USER_RESET_IRQ_ENABLE <= 1'b0;
         PULSE_LENGTH_FIELD <= `SRST_PULSE_LENGTH_FIELD_RESET;
      end else if (MODE_WRITE) begin
         USER_RESET_ENABLE <= USER_RESET_ENABLE_IN;
         USER_RESET_IRQ_ENABLE <= USER_RESET_IRQ_ENABLE_IN;
         PULSE_LENGTH_FIELD <= PULSE_LENGTH_IN;
      end
   end

   // level status, sticky seen flag where the set wins over the read
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         PIN_LEVEL_STATUS <= 1'b1;
         USER_RESET_SEEN <= 1'b0;
      end else begin
         PIN_LEVEL_STATUS <= pin_s2_ff;
         if (pin_prev_ff & ~pin_s2_ff & ~ext_req_ff)
            USER_RESET_SEEN <= 1'b1;
         else if (STATUS_READ)
            USER_RESET_SEEN <= 1'b0;
      end
   end

   // boot select captured three cycles after core rise
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         boot_cnt_ff <= 2'h0;
         boot_arm_ff <= 1'b0;
         BOOT_SELECT <= 1'b0;
      end else if (core_up & ~core_prev_ff) begin
         boot_cnt_ff <= 2'h1;
         boot_arm_ff <= 1'b1;
      end else if (boot_arm_ff) begin
         // Count started at one on the edge-detect cycle
         if (boot_cnt_ff == `SRST_BOOT_DELAY) begin
            BOOT_SELECT <= boot_s2_ff;
            boot_arm_ff <= 1'b0;
         end else begin
            boot_cnt_ff <= boot_cnt_ff + 2'h1;
         end
      end
   end

   // Reset state manager
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_proc = proc_rst_n_ff;
      nxt_per = per_rst_n_ff;
      nxt_bkp = bkp_rst_n_ff;
      nxt_ext = 1'b0;
      nxt_type = pend_type_ff;
      case (state_ff)
         `SRST_ST_BACKUP: begin
            nxt_proc = 1'b0;
            nxt_per = 1'b0;
            nxt_bkp = 1'b0;
            nxt_cnt = 16'h0000;
            // detector rise starts the startup counter
            if (bkp_ok)
               nxt_state = `SRST_ST_STARTUP;
         end
         `SRST_ST_STARTUP: begin
            if (cnt_ff >= startup_len - 16'h0001) begin
               nxt_cnt = 16'h0000;
               nxt_state = `SRST_ST_CLKRUN;
               nxt_type = `SRST_TYPE_GENERAL;
            end else begin
               nxt_cnt = cnt_ff + 16'h0001;
            end
         end
         `SRST_ST_CLKRUN: begin
            // clock runs, resets held three cycles
            // Counter enters at zero from every path
            if (cnt_ff == {14'h0000, `SRST_PROC_STARTUP} - 16'h0001) begin
               nxt_proc = 1'b1;
               nxt_per = 1'b1;
               nxt_bkp = 1'b1;
               nxt_state = `SRST_ST_RUN;
               nxt_ext = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 16'h0001;
            end
         end
         `SRST_ST_RUN: begin
            // core detector acts only after backup release
            if (!core_up) begin
               nxt_proc = 1'b0;
               nxt_per = 1'b0;
               nxt_state = `SRST_ST_CORE_OFF;
            end else if (user_trig & ~ext_req_ff) begin
               nxt_proc = 1'b0;
               nxt_per = 1'b0;
               nxt_state = `SRST_ST_USER;
            end
         end
         `SRST_ST_CORE_OFF: begin
            nxt_proc = 1'b0;
            nxt_per = 1'b0;
            nxt_cnt = 16'h0000;
            if (core_up) begin
               nxt_state = `SRST_ST_CLKRUN;
               nxt_type = `SRST_TYPE_WAKEUP;
            end
         end
         `SRST_ST_USER: begin
            // Internal resets stay low until the line is seen high again
            nxt_cnt = 16'h0000;
            if (!core_up) begin
               nxt_state = `SRST_ST_CORE_OFF;
            end else if (!pin_low) begin
               nxt_state = `SRST_ST_CLKRUN;
               nxt_type = `SRST_TYPE_USER;
            end
         end
         default: nxt_state = `SRST_ST_BACKUP;
      endcase
   end

   // State, counter and reset flops; backup loss wins over every state
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_ff <= `SRST_ST_BACKUP;
         cnt_ff <= 16'h0000;
         proc_rst_n_ff <= 1'b0;
         per_rst_n_ff <= 1'b0;
         bkp_rst_n_ff <= 1'b0;
         pend_type_ff <= `SRST_TYPE_GENERAL;
         LAST_RESET_TYPE <= `SRST_TYPE_GENERAL;
      end else if (!bkp_ok) begin
         state_ff <= `SRST_ST_BACKUP;
         cnt_ff <= 16'h0000;
         proc_rst_n_ff <= 1'b0;
         per_rst_n_ff <= 1'b0;
         bkp_rst_n_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         proc_rst_n_ff <= nxt_proc;
         per_rst_n_ff <= nxt_per;
         bkp_rst_n_ff <= nxt_bkp;
         pend_type_ff <= nxt_type;
         // type loaded only at processor release
         if (nxt_proc & ~proc_rst_n_ff)
            LAST_RESET_TYPE <= nxt_type;
      end
   end

   // pin driver: low from reset until pulse count ends
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         PIN_OUT <= 1'b0;
         ext_req_ff <= 1'b1;
         pulse_cnt_ff <= 17'h00000;
      end else if (!bkp_ok || !core_up || state_ff == `SRST_ST_BACKUP || state_ff == `SRST_ST_STARTUP ||
                   state_ff == `SRST_ST_CORE_OFF) begin
         // pin held with the other resets while a supply is down
         PIN_OUT <= 1'b0;
         ext_req_ff <= 1'b1;
         pulse_cnt_ff <= 17'h00000;
      end else if (nxt_ext) begin
         // every release drives its own pulse, user reset included
         PIN_OUT <= 1'b0;
         ext_req_ff <= 1'b1;
         pulse_cnt_ff <= 17'h00001;
      end else if (pulse_cnt_ff != 17'h00000) begin
         if (pulse_cnt_ff >= pulse_len) begin
            PIN_OUT <= 1'b1;
            pulse_cnt_ff <= 17'h00000;
         end else begin
            pulse_cnt_ff <= pulse_cnt_ff + 17'h00001;
         end
      end else if (PIN_OUT & pin_s2_ff) begin
         // Own pulse seen gone from the line before user detection rearms
         ext_req_ff <= 1'b0;
      end
   end
endmodule // srst_controller
`default_nettype wire

// [tb/srst_pin_model.sv]
// Reset pin line with pull-up, shared by the controller and an outside device
`timescale 1ns/100ps
`default_nettype none
module srst_pin_model (
   input wire logic pin_out,
   input wire logic pin_oe_n,
   input wire logic ext_low,
   output logic pin_in
);
   // Open drain: the pull-up wins only when nobody pulls low
   assign pin_in = !(ext_low || (!pin_oe_n && !pin_out));
endmodule // srst_pin_model
`default_nettype wire

// [tb/srst_controller_asserts.sv]
// Concurrent checks on the reset controller ports
`timescale 1ns/100ps
`default_nettype none
module srst_controller_asserts #(
   parameter STARTUP_CYCLES = 1024
) (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic BACKUP_POR_N,
   input wire logic CORE_POR_N,
   input wire logic PIN_OUT,
   input wire logic STATUS_READ,
   input wire logic USER_RESET_ENABLE,
   input wire logic USER_RESET_IRQ_ENABLE,
   input wire logic [3:0] PULSE_LENGTH_FIELD,
   input wire logic USER_RESET_SEEN,
   input wire logic [2:0] LAST_RESET_TYPE,
   input wire logic USER_RESET_IRQ,
   input wire logic PROC_CLK_EN,
   input wire logic PROC_RESET_N,
   input wire logic WDT_RESET_N,
   input wire logic BACKUP_RESET_N,
   input wire logic PERIPH_RESET_N
);
   logic [16:0] low_cnt_ff;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // Pin pulse length counted from processor release
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         low_cnt_ff <= 17'h0;
      end else if (!PROC_RESET_N) begin
         low_cnt_ff <= 17'h0;
      end else if (!PIN_OUT) begin
         low_cnt_ff <= low_cnt_ff + 17'h1;
      end
   end
   sequence s_clk_run;
      (PROC_CLK_EN && !PROC_RESET_N)[*3] ##1 PROC_RESET_N;
   endsequence
   a_wdt_follows_proc: assert property (WDT_RESET_N == PROC_RESET_N)
      else $error("watchdog reset differs from processor reset");
   a_backup_low_all: assert property (!BACKUP_POR_N |-> !(PROC_RESET_N | BACKUP_RESET_N | PERIPH_RESET_N))
      else $error("reset released while backup supply low");
   a_core_low_hold: assert property (!CORE_POR_N |-> !PROC_RESET_N && !PERIPH_RESET_N)
      else $error("reset released while core supply low");
   a_type_at_release: assert property ($changed(LAST_RESET_TYPE) |-> $rose(PROC_RESET_N))
      else $error("reset type changed outside release");
   a_irq_level: assert property (USER_RESET_IRQ == (USER_RESET_SEEN && USER_RESET_IRQ_ENABLE && !USER_RESET_ENABLE))
      else $error("interrupt level wrong");
   a_clk_run_three: assert property ($rose(PROC_CLK_EN) |-> s_clk_run)
      else $error("clock run phase not three cycles");
   a_pulse_len: assert property ($rose(PIN_OUT) && PROC_RESET_N |-> low_cnt_ff == (17'h1 << (PULSE_LENGTH_FIELD + 5'h1)))
      else $error("pin pulse length wrong");
   a_seen_sticky: assert property (USER_RESET_SEEN && !STATUS_READ && BACKUP_POR_N |=> USER_RESET_SEEN)
      else $error("seen flag lost without read");
   a_user_gate: assert property ($fell(PROC_RESET_N) && CORE_POR_N && BACKUP_POR_N |->
      $past(USER_RESET_ENABLE && !USER_RESET_IRQ_ENABLE))
      else $error("user reset taken while disabled");
endmodule // srst_controller_asserts
bind srst_controller srst_controller_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.CLOCK, .RESET_N,
   .BACKUP_POR_N, .CORE_POR_N, .PIN_OUT, .STATUS_READ, .USER_RESET_ENABLE, .USER_RESET_IRQ_ENABLE,
   .PULSE_LENGTH_FIELD, .USER_RESET_SEEN, .LAST_RESET_TYPE, .USER_RESET_IRQ, .PROC_CLK_EN, .PROC_RESET_N,
   .WDT_RESET_N, .BACKUP_RESET_N, .PERIPH_RESET_N);
`default_nettype wire

// [tb/tb_srst_controller.sv]
// Self-checking bench for the slow-clock reset controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_srst_controller;
   logic clock = 1'b0, reset_n = 1'b0, bak_por_n = 1'b1, core_por_n = 1'b1;
   logic ext_low = 1'b0, boot_pin = 1'b0, mode_wr = 1'b0, ue_in = 1'b0, ie_in = 1'b0, st_rd = 1'b0;
   logic [3:0] len_in = 4'h0;
   wire pin_in, pin_out, pin_oe_n, boot_sel, ue, ie, lvl, seen, irq, clk_en, proc_n, wdt_n, bak_n, per_n;
   wire [3:0] len;
   wire [2:0] typ;
   int fails = 0, n_compared = 0, cyc = 0;
   srst_controller #(.STARTUP_CYCLES(4)) dut (.CLOCK(clock), .RESET_N(reset_n), .BACKUP_POR_N(bak_por_n),
      .CORE_POR_N(core_por_n), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
      .BOOT_SELECT_PIN(boot_pin), .BOOT_SELECT(boot_sel), .MODE_WRITE(mode_wr), .USER_RESET_ENABLE_IN(ue_in),
      .USER_RESET_IRQ_ENABLE_IN(ie_in), .PULSE_LENGTH_IN(len_in), .USER_RESET_ENABLE(ue),
      .USER_RESET_IRQ_ENABLE(ie), .PULSE_LENGTH_FIELD(len), .STATUS_READ(st_rd), .PIN_LEVEL_STATUS(lvl),
      .USER_RESET_SEEN(seen), .LAST_RESET_TYPE(typ), .USER_RESET_IRQ(irq), .PROC_CLK_EN(clk_en),
      .PROC_RESET_N(proc_n), .WDT_RESET_N(wdt_n), .BACKUP_RESET_N(bak_n), .PERIPH_RESET_N(per_n));
   srst_pin_model pin (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_low(ext_low), .pin_in(pin_in));
   initial forever #25 clock = ~clock;
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask
   task automatic mode(input logic u, input logic i, input logic [3:0] l);
      {ue_in, ie_in, len_in, mode_wr} = {u, i, l, 1'b1};
      tick(1);
      mode_wr = 1'b0;
      `CHK("mode", {u, i, l}, {ue, ie, len})
   endtask
   task automatic pulse_read;
      st_rd = 1'b1;
      tick(1);
      st_rd = 1'b0;
   endtask
   // Waits for processor release, then times the pin pulse
   task automatic release_chk(input logic [2:0] t, input int l);
      int k;
      for (k = 0; k < 100 && proc_n !== 1'b1; k++) tick(1);
      `CHK("type", t, typ)
      `CHK("periph", 3'h7, {per_n, wdt_n, clk_en})
      tick((1 << (l + 1)) - 1);
      `CHK("pin low", 2'h0, {pin_out, pin_oe_n})
      tick(1);
      `CHK("pin high", 2'h3, {pin_out, pin_oe_n})
   endtask
   task automatic results;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, far above the expected run of under a hundred cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         results;
      end
   end
   initial begin
      tick(5);
      `CHK("rst", 3'h0, {proc_n, bak_n, per_n})
      reset_n = 1'b1;
      tick(5);
      `CHK("startup", 1'b0, proc_n)
      release_chk(3'h0, 0);
      `CHK("backup rel", 1'b1, bak_n)
      mode(1'b1, 1'b0, 4'h1);
      ext_low = 1'b1;
      tick(6);
      `CHK("user hold", 4'h0, {proc_n, wdt_n, per_n, lvl})
      ext_low = 1'b0;
      release_chk(3'h4, 1);
      `CHK("seen", 1'b1, seen)
      pulse_read;
      `CHK("seen clr", 1'b0, seen)
      mode(1'b0, 1'b1, 4'h1);
      ext_low = 1'b1;
      tick(6);
      `CHK("no user", 3'h7, {proc_n, seen, irq})
      ext_low = 1'b0;
      pulse_read;
      `CHK("irq clr", 1'b0, irq)
      {core_por_n, boot_pin} = 2'b01;
      tick(3);
      `CHK("core low", 3'h2, {proc_n, bak_n, per_n})
      core_por_n = 1'b1;
      release_chk(3'h1, 1);
      `CHK("boot", 1'b1, boot_sel)
      bak_por_n = 1'b0;
      tick(3);
      `CHK("bak low", 7'h0, {proc_n, bak_n, per_n, len})
      bak_por_n = 1'b1;
      release_chk(3'h0, 0);
      results;
   end
endmodule // tb_srst_controller
`default_nettype wire
